// file: tb_top.sv
// self-checking bench for the 8-bit compare/pwm timer behind axi4-lite
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_CTL = tmr_pkg::TMR_OFF_CONTROL;
    localparam logic [7:0] A_CNT = tmr_pkg::TMR_OFF_COUNT;
    localparam logic [7:0] A_CMP = tmr_pkg::TMR_OFF_COMPARE;
    localparam logic [7:0] A_MSK = tmr_pkg::TMR_OFF_MASK;
    localparam logic [7:0] A_FLG = tmr_pkg::TMR_OFF_FLAGS;
    localparam logic [1:0] OK = tmr_pkg::TMR_RESP_OKAY;
    localparam logic [1:0] SE = tmr_pkg::TMR_RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, wave, oe_n, cmp_irq, ovf_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic ext_pin = 1'b0, gie = 1'b0, cmp_taken = 1'b0, ovf_taken = 1'b0;
    logic pdat = 1'b0, pdir = 1'b1;
    int err_count = 0, checks = 0, seed = 85, n;
    logic [7:0] v, m;

    // free-running bench clock, 10 ns period
    always #5 aclk = ~aclk;

    tmr_timer8 #(.ADDR_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_count_pin(ext_pin), .port_data_in(pdat), .port_dir_in(pdir),
        .cpu_int_enable(gie), .compare_vector_taken(cmp_taken),
        .overflow_vector_taken(ovf_taken), .wave_out_pin(wave), .wave_out_pin_oe_n(oe_n),
        .compare_irq_req(cmp_irq), .overflow_irq_req(ovf_irq));

    task automatic conclude();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one axi4-lite transfer; each channel is released at its own handshake edge
    task automatic bus(input bit wr, input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er, output logic [7:0] q);
        bit dn, ta, tw, tr;
        dn = 1'b0;
        q = 8'h00;
        @(posedge aclk);
        if (wr) begin
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        // look in the low phase at what the next edge will take, release after that edge
        for (int i = 0; i < 50 && !dn; i++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            if (wr && bvalid) begin
                dn = 1'b1;
                chk("bresp", {6'h0, er}, {6'h0, bresp});
            end
            if (!wr && rvalid) begin
                dn = 1'b1;
                q = rdata[7:0];
                chk("rresp", {6'h0, er}, {6'h0, rresp});
            end
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (dn) begin
                bready <= 1'b0;
                rready <= 1'b0;
            end
        end
        if (!dn) begin
            err_count++;
            conclude();
        end
    endtask

    // bounded wait for a one-bit output to reach a level, then compare it
    task automatic wait_bit(input string what, ref logic s, input logic e);
        @(negedge aclk);
        for (int i = 0; i < 600 && s !== e; i++) @(negedge aclk);
        chk(what, {7'h0, e}, {7'h0, s});
        if (s !== e) conclude();
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, A_CTL, 8'h00, OK, v);
        chk("control", 8'h00, v);
        bus(1, 8'h40, 8'h55, SE, v);
        bus(0, 8'h40, 8'h00, SE, v);
        chk("unmapped", 8'h00, v);
        $display("test reset_map done");
        // count model m follows software writes while the timer is stopped
        for (n = 0; n < 4; n++) begin
            m = 8'($random(seed));
            bus(1, A_CNT, m, OK, v);
            bus(0, A_CNT, 8'h00, OK, v);
            chk("count", m, v);
        end
        $display("test count_rw done");
        bus(1, A_CTL, 8'hB0, OK, v);
        wait_bit("wave", wave, 1'b1);
        chk("oe_n", 8'h00, {7'h0, oe_n});
        bus(0, A_CTL, 8'h00, OK, v);
        chk("control", 8'h30, v);
        bus(0, A_FLG, 8'h00, OK, v);
        chk("flags", 8'h00, v);
        bus(0, A_CNT, 8'h00, OK, v);
        chk("count", m, v);
        bus(1, A_CTL, 8'hE8, OK, v);
        repeat (4) @(posedge aclk);
        chk("wave", 8'h01, {7'h0, wave});
        $display("test force done");
        bus(1, A_CTL, 8'h00, OK, v);
        bus(1, A_CNT, 8'hFE, OK, v);
        bus(1, A_CMP, 8'h80, OK, v);
        bus(1, A_MSK, 8'h01, OK, v);
        gie <= 1'b1;
        bus(1, A_CTL, 8'h01, OK, v);
        wait_bit("ovf_irq", ovf_irq, 1'b1);
        bus(1, A_CTL, 8'h00, OK, v);
        bus(1, A_FLG, 8'h00, OK, v);
        bus(0, A_FLG, 8'h00, OK, v);
        chk("flags", 8'h01, v);
        bus(1, A_FLG, 8'h01, OK, v);
        bus(0, A_FLG, 8'h00, OK, v);
        chk("flags", 8'h00, v);
        wait_bit("ovf_irq", ovf_irq, 1'b0);
        $display("test overflow done");
        bus(1, A_CNT, 8'h10, OK, v);
        bus(1, A_CMP, 8'h12, OK, v);
        bus(1, A_MSK, 8'h02, OK, v);
        bus(1, A_CTL, 8'h01, OK, v);
        wait_bit("cmp_irq", cmp_irq, 1'b1);
        bus(1, A_CTL, 8'h00, OK, v);
        bus(0, A_FLG, 8'h00, OK, v);
        chk("flags", 8'h02, v);
        cmp_taken <= 1'b1;
        @(posedge aclk);
        cmp_taken <= 1'b0;
        bus(0, A_FLG, 8'h00, OK, v);
        chk("flags", 8'h00, v);
        $display("test compare done");
        // pwm runs with compare 0x80; force bit kept zero while pwm is selected
        bus(1, A_CMP, 8'h80, OK, v);
        bus(1, A_CTL, 8'h69, OK, v);
        wait_bit("wave", wave, 1'b0);
        wait_bit("wave", wave, 1'b1);
        bus(1, A_CTL, 8'h61, OK, v);
        wait_bit("wave", wave, 1'b0);
        wait_bit("wave", wave, 1'b1);
        // clear-on-match toggling at div 8; normal mode would miss the bound
        bus(1, A_CTL, 8'h00, OK, v);
        bus(1, A_CMP, 8'h04, OK, v);
        bus(1, A_CNT, 8'h00, OK, v);
        bus(1, A_CTL, 8'h1A, OK, v);
        wait_bit("wave", wave, 1'b0);
        wait_bit("wave", wave, 1'b1);
        $display("test pwm_ctc done");
        bus(1, A_CTL, 8'h00, OK, v);
        bus(1, A_CNT, 8'h00, OK, v);
        bus(1, A_CTL, 8'h07, OK, v);
        // three slow rising edges on the count pin; falls must not count
        repeat (3) begin
            ext_pin <= 1'b1;
            repeat (8) @(posedge aclk);
            ext_pin <= 1'b0;
            repeat (8) @(posedge aclk);
        end
        bus(0, A_CNT, 8'h00, OK, v);
        chk("count", 8'h03, v);
        $display("test ext_count done");
        // output mode off: pin shows port data, driver follows direction only
        wait_bit("pin", wave, 1'b0);
        @(posedge aclk);
        pdir <= 1'b0;
        pdat <= 1'b1;
        wait_bit("oe_n", oe_n, 1'b1);
        wait_bit("pin", wave, 1'b1);
        $display("test pin_mux done");
        conclude();
    end
endmodule

// file: tmr_clock_select.sv
// count-enable source: prescaler taps or synchronised external pin edges
module tmr_clock_select (
    input logic aclk,
    input logic aresetn,
    input tmr_pkg::tmr_clksel_t clock_select,
    input logic ext_count_pin,
    output logic tick
);
    logic [tmr_pkg::TMR_PRESC_W-1:0] presc_ff;
    logic sync1_ff, sync2_ff, sync3_ff, level_ff;
    logic settled, rise, fall, nxt_tick;

    // free running divider, taps are all-ones of its low bits
    always_ff @(posedge aclk) begin
        if (!aresetn) presc_ff <= '0;
        else presc_ff <= presc_ff + 1'b1;
    end

    // three stage synchroniser; level only moves once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            sync1_ff <= ext_count_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (settled) level_ff <= sync3_ff;
        end
    end

    // pin direction is not consulted, so software driving the pin still counts
    assign settled = (sync2_ff == sync3_ff);
    assign rise = settled && sync3_ff && !level_ff;
    assign fall = settled && !sync3_ff && level_ff;

    always_comb begin
        unique case (clock_select)
            tmr_pkg::TMR_CS_STOP: nxt_tick = 1'b0;
            tmr_pkg::TMR_CS_DIV1: nxt_tick = 1'b1;
            tmr_pkg::TMR_CS_DIV8: nxt_tick = &presc_ff[2:0];
            tmr_pkg::TMR_CS_DIV64: nxt_tick = &presc_ff[5:0];
            tmr_pkg::TMR_CS_DIV256: nxt_tick = &presc_ff[7:0];
            tmr_pkg::TMR_CS_DIV1024: nxt_tick = &presc_ff[9:0];
            tmr_pkg::TMR_CS_EXT_FALL: nxt_tick = fall;
            tmr_pkg::TMR_CS_EXT_RISE: nxt_tick = rise;
        endcase
    end

    // registered so a stop selection silences ticks one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) tick <= 1'b0;
        else tick <= nxt_tick;
    end
endmodule

// file: tmr_pkg.sv
// constants, types and register map of the 8-bit compare/pwm timer
// Function
// - force strobe acts only in normal or clear-on-match mode
// - force strobe applies the selected compare action at once, one cycle
// - force strobe sets no flag, raises no interrupt, never clears counter
// - force bit always reads back as zero
// - mode bits 6 (low) and 3 (high): normal, phase pwm, clear, fast pwm
// - top is 0xFF except compare in clear mode; pwm buffers compare
// - overflow flag at MAX, or at bottom reversal in phase-correct mode
// - nonzero output mode overrides port data; direction bit enables driver
// - non-pwm output modes: off, toggle, clear, set on match
// - fast pwm: off, reserved, clear-match/set-top, set-match/clear-top
// - phase pwm: code 10 clears up, sets down; 11 opposite
// - pwm with compare at top and upper bit set: act at top only
// - clock select: stop, div 1, 8, 64, 256, 1024, pin fall, pin rise
// - external pin edges count even when the pin is an output
// - counter readable and writable; write blocks next tick's match
// - compare always checked; match sets flag and drives output action
// - compare irq needs enable bit 1, global enable and compare flag
// - overflow irq needs enable bit 0, global enable and overflow flag
// - compare flag cleared by vector taken or writing one
// - overflow flag cleared by vector taken or writing one
// - fast pwm counts up to MAX then wraps to zero
// - phase pwm counts up to MAX, then down to zero, repeating
package tmr_pkg;
    localparam logic [7:0] TMR_OFF_CONTROL = 8'h24;
    localparam logic [7:0] TMR_OFF_COUNT = 8'h28;
    localparam logic [7:0] TMR_OFF_COMPARE = 8'h2C;
    localparam logic [7:0] TMR_OFF_MASK = 8'h30;
    localparam logic [7:0] TMR_OFF_FLAGS = 8'h34;
    localparam int TMR_BIT_FORCE = 7;
    localparam int TMR_BIT_WAVE_LOW = 6;
    localparam int TMR_BIT_OUT_UPPER = 5;
    localparam int TMR_BIT_OUT_LOWER = 4;
    localparam int TMR_BIT_WAVE_HIGH = 3;
    localparam int TMR_BIT_CMP = 1;
    localparam int TMR_BIT_OVF = 0;
    localparam logic [7:0] TMR_CONTROL_RST = 8'h00;
    localparam logic [7:0] TMR_COUNT_RST = 8'h00;
    localparam logic [7:0] TMR_COMPARE_RST = 8'h00;
    localparam logic [1:0] TMR_MASK_RST = 2'h0;
    localparam logic [7:0] TMR_MAX = 8'hFF;
    localparam logic [7:0] TMR_BOTTOM = 8'h00;
    localparam int TMR_PRESC_W = 10;
    localparam logic [1:0] TMR_RESP_OKAY = 2'h0;
    localparam logic [1:0] TMR_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        TMR_NORMAL, TMR_PHASE_PWM, TMR_CLEAR_MATCH, TMR_FAST_PWM
    } tmr_mode_t;
    typedef enum logic [2:0] {
        TMR_CS_STOP, TMR_CS_DIV1, TMR_CS_DIV8, TMR_CS_DIV64,
        TMR_CS_DIV256, TMR_CS_DIV1024, TMR_CS_EXT_FALL, TMR_CS_EXT_RISE
    } tmr_clksel_t;
endpackage

// file: tmr_timer8.sv
// 8-bit timer/counter with one compare channel behind an axi4-lite slave
//
// The AXI4-Lite slave port was decided locally.
module tmr_timer8 #(
    parameter int ADDR_W = 8
) (
    input logic aclk,
    input logic aresetn,
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic ext_count_pin,
    input logic port_data_in,
    input logic port_dir_in,
    input logic cpu_int_enable,
    input logic compare_vector_taken,
    input logic overflow_vector_taken,
    output logic wave_out_pin,
    output logic wave_out_pin_oe_n,
    output logic compare_irq_req,
    output logic overflow_irq_req
);
    tmr_wave_if wif ();

    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic aw_held_ff, w_held_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic [6:0] ctrl_ff;
    logic [7:0] cnt_ff, cmp_ff, cmp_eff_ff;
    logic [1:0] mask_ff;
    logic dir_up_ff, blocked_ff, force_ff;
    logic cmp_flag_ff, ovf_flag_ff;
    logic cmp_irq_ff, ovf_irq_ff, pin_ff, pin_oe_n_ff;
    logic aw_hs, w_hs, ar_hs, do_write, wr_en;
    logic nxt_aw_held, nxt_w_held;
    logic wr_ctrl, wr_count, wr_cmp, wr_mask, wr_flags, wr_hit;
    logic [31:0] nxt_rdata;
    logic nxt_rd_hit;
    tmr_pkg::tmr_mode_t mode;
    logic [1:0] out_mode;
    logic pwm, tick, match_ok, ovf_event;
    logic [7:0] top;

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wave_out_pin = pin_ff;
    assign wave_out_pin_oe_n = pin_oe_n_ff;
    assign compare_irq_req = cmp_irq_ff;
    assign overflow_irq_req = ovf_irq_ff;

    // write channel: address and data taken independently, applied together
    assign aw_hs = s_axi_awvalid && awready_ff;
    assign w_hs = s_axi_wvalid && wready_ff;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign nxt_aw_held = (aw_held_ff || aw_hs) && !do_write;
    assign nxt_w_held = (w_held_ff || w_hs) && !do_write;
    assign wr_en = do_write && wstrb0_ff;
    assign wr_ctrl = wr_en && (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_CONTROL));
    assign wr_count = wr_en && (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_COUNT));
    assign wr_cmp = wr_en && (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_COMPARE));
    assign wr_mask = wr_en && (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_MASK));
    assign wr_flags = wr_en && (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_FLAGS));
    assign wr_hit = (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_CONTROL))
        || (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_COUNT))
        || (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_COMPARE))
        || (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_MASK))
        || (awaddr_ff == ADDR_W'(tmr_pkg::TMR_OFF_FLAGS));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= !nxt_aw_held;
            wready_ff <= !nxt_w_held;
            if (aw_hs) awaddr_ff <= s_axi_awaddr;
            if (w_hs) begin
                wdata_ff <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
        end
    end

    // write response; unmapped address answers slverr and changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= tmr_pkg::TMR_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? tmr_pkg::TMR_RESP_OKAY : tmr_pkg::TMR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read mux, upper bits read as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rd_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_W'(tmr_pkg::TMR_OFF_CONTROL): nxt_rdata[7:0] = {1'b0, ctrl_ff};
            ADDR_W'(tmr_pkg::TMR_OFF_COUNT): nxt_rdata[7:0] = cnt_ff;
            ADDR_W'(tmr_pkg::TMR_OFF_COMPARE): nxt_rdata[7:0] = cmp_ff;
            ADDR_W'(tmr_pkg::TMR_OFF_MASK): nxt_rdata[1:0] = mask_ff;
            ADDR_W'(tmr_pkg::TMR_OFF_FLAGS): nxt_rdata[1:0] = {cmp_flag_ff, ovf_flag_ff};
            default: nxt_rd_hit = 1'b0;
        endcase
    end

    // read channel: one read in flight, data held until rready
    assign ar_hs = s_axi_arvalid && arready_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= tmr_pkg::TMR_RESP_OKAY;
        end else begin
            arready_ff <= !(ar_hs || (rvalid_ff && !s_axi_rready));
            if (ar_hs) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= nxt_rdata;
                rresp_ff <= nxt_rd_hit ? tmr_pkg::TMR_RESP_OKAY : tmr_pkg::TMR_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // control, compare and mask registers; force bit is never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= tmr_pkg::TMR_CONTROL_RST[6:0];
            cmp_ff <= tmr_pkg::TMR_COMPARE_RST;
            mask_ff <= tmr_pkg::TMR_MASK_RST;
        end else begin
            if (wr_ctrl) ctrl_ff <= wdata_ff[6:0];
            if (wr_cmp) cmp_ff <= wdata_ff;
            if (wr_mask) mask_ff <= wdata_ff[1:0];
        end
    end

    // force strobe only honoured for non-pwm modes of the value being written
    always_ff @(posedge aclk) begin
        if (!aresetn) force_ff <= 1'b0;
        else force_ff <= wr_ctrl && wdata_ff[tmr_pkg::TMR_BIT_FORCE]
            && !wdata_ff[tmr_pkg::TMR_BIT_WAVE_LOW];
    end

    assign mode = tmr_pkg::tmr_mode_t'({ctrl_ff[tmr_pkg::TMR_BIT_WAVE_HIGH],
        ctrl_ff[tmr_pkg::TMR_BIT_WAVE_LOW]});
    assign out_mode = {ctrl_ff[tmr_pkg::TMR_BIT_OUT_UPPER], ctrl_ff[tmr_pkg::TMR_BIT_OUT_LOWER]};
    assign pwm = ctrl_ff[tmr_pkg::TMR_BIT_WAVE_LOW];
    assign top = (mode == tmr_pkg::TMR_CLEAR_MATCH) ? cmp_eff_ff : tmr_pkg::TMR_MAX;
    // a blocked tick still counts; it only loses its match
    assign match_ok = tick && (cnt_ff == cmp_eff_ff) && !blocked_ff;
    assign ovf_event = tick && ((mode == tmr_pkg::TMR_PHASE_PWM)
        ? (!dir_up_ff && cnt_ff == tmr_pkg::TMR_BOTTOM)
        : (cnt_ff == tmr_pkg::TMR_MAX));

    tmr_clock_select u_clksel (
        .aclk(aclk),
        .aresetn(aresetn),
        .clock_select(tmr_pkg::tmr_clksel_t'(ctrl_ff[2:0])),
        .ext_count_pin(ext_count_pin),
        .tick(tick)
    );

    // compare buffer: immediate outside pwm, loaded at top in pwm
    always_ff @(posedge aclk) begin
        if (!aresetn) cmp_eff_ff <= tmr_pkg::TMR_COMPARE_RST;
        else if (!pwm) cmp_eff_ff <= wr_cmp ? wdata_ff : cmp_ff;
        else if (tick && cnt_ff == tmr_pkg::TMR_MAX) cmp_eff_ff <= cmp_ff;
    end

    // counter sequence per mode; software write has priority over a tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= tmr_pkg::TMR_COUNT_RST;
            dir_up_ff <= 1'b1;
        end else if (wr_count) begin
            cnt_ff <= wdata_ff;
        end else if (tick) begin
            unique case (mode)
                tmr_pkg::TMR_NORMAL, tmr_pkg::TMR_FAST_PWM: begin
                    cnt_ff <= cnt_ff + 8'h01;
                    dir_up_ff <= 1'b1;
                end
                tmr_pkg::TMR_CLEAR_MATCH: begin
                    // forced compares never reach here, so they cannot clear
                    cnt_ff <= (match_ok && cnt_ff == top) ? tmr_pkg::TMR_BOTTOM
                        : cnt_ff + 8'h01;
                    dir_up_ff <= 1'b1;
                end
                tmr_pkg::TMR_PHASE_PWM: begin
                    if (dir_up_ff && cnt_ff == tmr_pkg::TMR_MAX) begin
                        dir_up_ff <= 1'b0;
                        cnt_ff <= cnt_ff - 8'h01;
                    end else if (!dir_up_ff && cnt_ff == tmr_pkg::TMR_BOTTOM) begin
                        dir_up_ff <= 1'b1;
                        cnt_ff <= cnt_ff + 8'h01;
                    end else begin
                        cnt_ff <= dir_up_ff ? cnt_ff + 8'h01 : cnt_ff - 8'h01;
                    end
                end
            endcase
        end
    end

    // a counter write removes the match of the next tick
    always_ff @(posedge aclk) begin
        if (!aresetn) blocked_ff <= 1'b0;
        else if (wr_count) blocked_ff <= 1'b1;
        else if (tick) blocked_ff <= 1'b0;
    end

    // flags: hardware set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_flag_ff <= 1'b0;
            ovf_flag_ff <= 1'b0;
        end else begin
            cmp_flag_ff <= match_ok || (cmp_flag_ff && !compare_vector_taken
                && !(wr_flags && wdata_ff[tmr_pkg::TMR_BIT_CMP]));
            ovf_flag_ff <= ovf_event || (ovf_flag_ff && !overflow_vector_taken
                && !(wr_flags && wdata_ff[tmr_pkg::TMR_BIT_OVF]));
        end
    end

    // interrupt requests gated by enable bits and the global enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_irq_ff <= 1'b0;
            ovf_irq_ff <= 1'b0;
        end else begin
            cmp_irq_ff <= mask_ff[tmr_pkg::TMR_BIT_CMP] && cpu_int_enable && cmp_flag_ff;
            ovf_irq_ff <= mask_ff[tmr_pkg::TMR_BIT_OVF] && cpu_int_enable && ovf_flag_ff;
        end
    end

    assign wif.tick = tick;
    assign wif.count = cnt_ff;
    assign wif.cmp = cmp_eff_ff;
    assign wif.mode = mode;
    assign wif.out_mode = out_mode;
    assign wif.count_up = dir_up_ff;
    assign wif.match = match_ok;
    assign wif.force_cmp = force_ff;

    tmr_wave_gen u_wave (
        .aclk(aclk),
        .aresetn(aresetn),
        .wif(wif)
    );

    // pin mux; the driver follows only the direction bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_ff <= 1'b0;
            pin_oe_n_ff <= 1'b1;
        end else begin
            pin_ff <= (out_mode != 2'h0) ? wif.wave : port_data_in;
            pin_oe_n_ff <= !port_dir_in;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_force_non_pwm: assert property (force_ff |-> !pwm)
        else $error("force strobe seen in a pwm mode");
    a_force_no_flag: assert property ($rose(cmp_flag_ff) |-> $past(match_ok))
        else $error("compare flag set without a real match");
    a_ctrl_force_zero: assert property (
        ar_hs && s_axi_araddr == ADDR_W'(tmr_pkg::TMR_OFF_CONTROL) |=> !rdata_ff[7])
        else $error("force bit read back as one");
    a_ovf_cause: assert property ($rose(ovf_flag_ff) |-> $past(ovf_event))
        else $error("overflow flag without overflow event");
    a_cmp_irq_gate: assert property (cmp_irq_ff |-> $past(cmp_flag_ff && cpu_int_enable))
        else $error("compare irq without flag and global enable");
    a_ovf_irq_gate: assert property (ovf_irq_ff |-> $past(mask_ff[0] && ovf_flag_ff))
        else $error("overflow irq without enable and flag");
    a_cmp_w1c: assert property (wr_flags && wdata_ff[1] && !match_ok |=> !cmp_flag_ff)
        else $error("compare flag not cleared by write of one");
    // the block flag stands from the counter write until the next tick consumes it
    a_count_block: assert property (blocked_ff && tick |-> !match_ok)
        else $error("match not blocked after counter write");
    a_fast_wrap: assert property (mode == tmr_pkg::TMR_FAST_PWM && tick && !wr_count
        && cnt_ff == tmr_pkg::TMR_MAX |=> cnt_ff == tmr_pkg::TMR_BOTTOM)
        else $error("fast pwm did not wrap to zero");
    a_phase_turn: assert property (mode == tmr_pkg::TMR_PHASE_PWM && tick && !wr_count
        && dir_up_ff && cnt_ff == tmr_pkg::TMR_MAX |=> !dir_up_ff && cnt_ff == 8'hFE)
        else $error("phase pwm did not turn at max");
    a_stop_no_tick: assert property (ctrl_ff[2:0] == 3'h0 ##1 ctrl_ff[2:0] == 3'h0
        |-> !tick)
        else $error("tick while clock stopped");

    c_fast_wrap: cover property (mode == tmr_pkg::TMR_FAST_PWM && ovf_event);
    c_phase_bottom: cover property (mode == tmr_pkg::TMR_PHASE_PWM && ovf_event);
    c_forced: cover property (force_ff && out_mode == 2'h1);
    c_ctc_clear: cover property (mode == tmr_pkg::TMR_CLEAR_MATCH && match_ok);
endmodule

// file: tmr_wave_gen.sv
// waveform output register driven by matches, top events and force strobes
module tmr_wave_gen (
    input logic aclk,
    input logic aresetn,
    tmr_wave_if.gen wif
);
    logic wave_ff;
    logic at_top, special, hit;

    assign wif.wave = wave_ff;
    assign at_top = wif.tick && (wif.count == tmr_pkg::TMR_MAX);
    // compare parked at top with upper bit set: ignore match, act at top
    assign special = (wif.cmp == tmr_pkg::TMR_MAX) && wif.out_mode[1];
    assign hit = wif.match && !special;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_ff <= 1'b0;
        end else if (wif.force_cmp || (wif.match && !wif.mode[0])) begin
            // force uses the non-pwm table, never touches flags
            unique case (wif.out_mode)
                2'h0: wave_ff <= wave_ff;
                2'h1: wave_ff <= !wave_ff;
                2'h2: wave_ff <= 1'b0;
                2'h3: wave_ff <= 1'b1;
            endcase
        end else if (wif.mode == tmr_pkg::TMR_FAST_PWM && wif.out_mode[1]) begin
            if (at_top) wave_ff <= !wif.out_mode[0];
            else if (hit) wave_ff <= wif.out_mode[0];
        end else if (wif.mode == tmr_pkg::TMR_PHASE_PWM && wif.out_mode[1]) begin
            if (special && at_top && wif.count_up) wave_ff <= !wif.out_mode[0];
            else if (hit) wave_ff <= wif.count_up ? wif.out_mode[0] : !wif.out_mode[0];
        end
    end
endmodule

// file: tmr_wave_if.sv
// signals shared between the counter core and the waveform generator
interface tmr_wave_if;
    logic tick;
    logic [7:0] count;
    logic [7:0] cmp;
    tmr_pkg::tmr_mode_t mode;
    logic [1:0] out_mode;
    logic count_up;
    logic match;
    logic force_cmp;
    logic wave;
    modport core (output tick, count, cmp, mode, out_mode, count_up, match, force_cmp,
        input wave);
    modport gen (input tick, count, cmp, mode, out_mode, count_up, match, force_cmp,
        output wave);
endinterface
